/* verilog/tx_channel_pkg.sv */
// Constants and types shared by the asynchronous transmit channel
package tx_channel_pkg;
  localparam int ADDR_WIDTH = 8;
  localparam int DATA_WIDTH = 16;
  localparam logic [7:0] DATA_OFF = 8'h00;
  localparam logic [7:0] MODE_OFF = 8'h04;
  localparam logic [7:0] STATUS_OFF = 8'h08;
  localparam logic [7:0] START_OFF = 8'h0c;
  localparam logic [7:0] STOP_OFF = 8'h10;
  localparam logic [7:0] OE_OFF = 8'h14;
  localparam logic [7:0] OUT_OFF = 8'h18;
  localparam logic [7:0] PER_OFF = 8'h1c;
  localparam int DIV_LSB = 9;
  localparam int DIV_WIDTH = 7;
  localparam int WORD_WIDTH = 9;
  localparam int MODE_ISS_BIT = 0;
  localparam int MODE_PAR_LSB = 1;
  localparam int MODE_LSB_FIRST_BIT = 3;
  localparam int MODE_LEN_LSB = 4;
  localparam int MODE_STOP2_BIT = 6;
  localparam int MODE_INV_BIT = 7;
  localparam int MODE_PRESC_LSB = 8;
  localparam int STAT_BFF_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_OPER_BIT = 2;
  localparam int OUT_DATA_BIT = 0;
  localparam int OUT_CLK_BIT = 1;
  localparam logic [1:0] LEN_NINE = 2'h3;
  localparam logic [1:0] LEN_EIGHT = 2'h2;
  localparam logic [1:0] LEN_RESET = 2'h2;
  localparam logic [6:0] DIV_MIN = 7'h02;
  localparam logic [6:0] DIV_RESET = 7'h02;
  localparam logic [3:0] PRESC_RESET = 4'h0;
  localparam logic OUT_DATA_RESET = 1'b1;
  localparam logic OUT_CLK_RESET = 1'b1;
  localparam logic PER_RESET = 1'b1;
  typedef enum logic [1:0] {
    PAR_NONE = 2'b00,
    PAR_ZERO = 2'b01,
    PAR_EVEN = 2'b10,
    PAR_ODD = 2'b11
  } parity_type;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_DATA = 3'b010,
    ST_PARITY = 3'b011,
    ST_STOP = 3'b100
  } tx_state_type;
endpackage

/* verilog/channel_clock_divider.sv */
// Prescaler that makes the channel operating clock enable
`timescale 1ns/1ps
module channel_clock_divider #(
  parameter int CNT_WIDTH = 15
) (
  input wire logic core_clk, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic [3:0] presc_sel, // Divide by two to this power
  output logic ch_en // One-cycle enable at channel rate
);
  logic [CNT_WIDTH-1:0] cnt_reg;
  logic [CNT_WIDTH-1:0] mask;

  assign mask = CNT_WIDTH'((32'h1 << presc_sel) - 32'h1);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ch_en <= 1'b0;
    end else begin
      ch_en <= (cnt_reg & mask) == mask;
    end
  end
endmodule

/* verilog/async_serial_transmit_channel.sv */
// Transmit channel of the asynchronous serial pair with its registers
`timescale 1ns/1ps
module async_serial_transmit_channel (
  input wire logic core_clk, // System clock, 50 MHz
  input wire logic nrst, // Synchronous reset, active low
  input wire logic [7:0] addr, // Register byte address
  input wire logic [15:0] wdata, // Write data
  input wire logic wr_en, // Write strobe
  input wire logic rd_en, // Read strobe
  output logic [15:0] rdata, // Read data, cycle after strobe
  output logic transmit_line, // Serial transmit pin
  output logic serial_clock_output, // Clock level register, software owned here
  output logic transmit_interrupt // One-cycle interrupt pulse
);
  logic per_reg;
  logic unit_rst_n;
  logic ch_en;
  logic [6:0] div_reg;
  logic [8:0] buf_reg;
  logic bff_reg;
  logic iss_reg;
  tx_channel_pkg::parity_type par_reg;
  logic lsb_reg;
  logic [1:0] len_reg;
  logic stop2_reg;
  logic inv_reg;
  logic [3:0] presc_reg;
  logic oper_reg;
  logic oe_reg;
  logic so_reg;
  logic cko_reg;
  tx_channel_pkg::tx_state_type state_reg;
  logic [7:0] tick_reg;
  logic [3:0] idx_reg;
  logic stop_cnt_reg;
  logic [8:0] shift_reg;
  logic iss_last_reg;
  logic irq_reg;
  logic [15:0] rdata_reg;
  logic wr_data, wr_mode, wr_start, wr_stop, wr_oe, wr_out, wr_per;
  logic [6:0] eff_div;
  logic bit_done;
  logic [3:0] nbits;
  logic load;
  logic final_stop;
  logic frame_end;
  logic frame_level;
  logic par_bit;

  function automatic logic [3:0] frame_len(input logic [1:0] len);
    if (len == tx_channel_pkg::LEN_NINE) begin
      return 4'h9;
    end else if (len == tx_channel_pkg::LEN_EIGHT) begin
      return 4'h8;
    end
    return 4'h7;
  endfunction

  function automatic logic pick_bit(input logic [8:0] d, input logic [3:0] idx,
                                    input logic [3:0] n, input logic lsb);
    if (lsb) begin
      return d[idx];
    end
    return d[4'(n - 4'h1 - idx)];
  endfunction

  function automatic logic parity_of(input logic [8:0] d, input logic [3:0] n);
    logic p;
    p = 1'b0;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < n) begin
        p = p ^ d[i];
      end
    end
    return p;
  endfunction

  function automatic logic wr_hit(input logic we, input logic [7:0] a,
                                  input logic [7:0] off);
    return we && (a == off);
  endfunction

  assign wr_data = wr_hit(wr_en, addr, tx_channel_pkg::DATA_OFF);
  assign wr_mode = wr_hit(wr_en, addr, tx_channel_pkg::MODE_OFF);
  assign wr_start = wr_hit(wr_en, addr, tx_channel_pkg::START_OFF) && wdata[0];
  assign wr_stop = wr_hit(wr_en, addr, tx_channel_pkg::STOP_OFF) && wdata[0];
  assign wr_oe = wr_hit(wr_en, addr, tx_channel_pkg::OE_OFF);
  assign wr_out = wr_hit(wr_en, addr, tx_channel_pkg::OUT_OFF);
  assign wr_per = wr_hit(wr_en, addr, tx_channel_pkg::PER_OFF);

  // Clearing the enable holds every other flop of the unit in reset
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      per_reg <= tx_channel_pkg::PER_RESET;
    end else if (wr_per) begin
      per_reg <= wdata[0];
    end
  end
  assign unit_rst_n = nrst & per_reg;

  channel_clock_divider #(
    .CNT_WIDTH(15)
  ) u_divider (
    .core_clk(core_clk),
    .rst_n(unit_rst_n),
    .presc_sel(presc_reg),
    .ch_en(ch_en)
  );

  // Divider values below the minimum are run at the minimum
  assign eff_div = (div_reg < tx_channel_pkg::DIV_MIN) ? tx_channel_pkg::DIV_MIN : div_reg;
  assign bit_done = ch_en && (tick_reg == {eff_div, 1'b1});
  assign nbits = frame_len(len_reg);
  assign load = (state_reg == tx_channel_pkg::ST_IDLE) && oper_reg && bff_reg && !wr_stop;
  assign final_stop = (state_reg == tx_channel_pkg::ST_STOP) && (!stop2_reg || stop_cnt_reg);
  assign frame_end = final_stop && bit_done && !wr_stop;

  always_comb begin
    case (par_reg)
      tx_channel_pkg::PAR_ZERO: par_bit = 1'b0;
      tx_channel_pkg::PAR_EVEN: par_bit = parity_of(shift_reg, nbits);
      tx_channel_pkg::PAR_ODD: par_bit = ~parity_of(shift_reg, nbits);
      default: par_bit = 1'b0;
    endcase
  end

  always_comb begin
    case (state_reg)
      tx_channel_pkg::ST_START: frame_level = 1'b0;
      tx_channel_pkg::ST_DATA: frame_level = pick_bit(shift_reg, idx_reg, nbits, lsb_reg);
      tx_channel_pkg::ST_PARITY: frame_level = par_bit;
      default: frame_level = 1'b1;
    endcase
  end

  // Data register: baud divider above, transmit word below
  always_ff @(posedge core_clk) begin
    if (!unit_rst_n) begin
      div_reg <= tx_channel_pkg::DIV_RESET;
      buf_reg <= '0;
    end else if (wr_data) begin
      div_reg <= wdata[tx_channel_pkg::DIV_LSB +: tx_channel_pkg::DIV_WIDTH];
      buf_reg <= wdata[tx_channel_pkg::WORD_WIDTH-1:0];
    end
  end

  // A write in the cycle of a load keeps the flag set
  always_ff @(posedge core_clk) begin
    if (!unit_rst_n) begin
      bff_reg <= 1'b0;
    end else if (wr_data) begin
      bff_reg <= 1'b1;
    end else if (load) begin
      bff_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!unit_rst_n) begin
      iss_reg <= 1'b0;
      par_reg <= tx_channel_pkg::PAR_NONE;
      lsb_reg <= 1'b0;
      len_reg <= tx_channel_pkg::LEN_RESET;
      stop2_reg <= 1'b0;
      inv_reg <= 1'b0;
      presc_reg <= tx_channel_pkg::PRESC_RESET;
    end else if (wr_mode) begin
      iss_reg <= wdata[tx_channel_pkg::MODE_ISS_BIT];
      par_reg <= tx_channel_pkg::parity_type'(wdata[tx_channel_pkg::MODE_PAR_LSB +: 2]);
      lsb_reg <= wdata[tx_channel_pkg::MODE_LSB_FIRST_BIT];
      len_reg <= wdata[tx_channel_pkg::MODE_LEN_LSB +: 2];
      stop2_reg <= wdata[tx_channel_pkg::MODE_STOP2_BIT];
      inv_reg <= wdata[tx_channel_pkg::MODE_INV_BIT];
      presc_reg <= wdata[tx_channel_pkg::MODE_PRESC_LSB +: 4];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!unit_rst_n) begin
      oper_reg <= 1'b0;
    end else if (wr_start) begin
      oper_reg <= 1'b1;
    end else if (wr_stop) begin
      oper_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!unit_rst_n) begin
      oe_reg <= 1'b0;
    end else if (wr_oe) begin
      oe_reg <= wdata[0];
    end
  end

  // Software owns the line unless the shifter is running and enabled
  always_ff @(posedge core_clk) begin
    if (!unit_rst_n) begin
      so_reg <= tx_channel_pkg::OUT_DATA_RESET;
    end else if (oper_reg && oe_reg) begin
      so_reg <= frame_level ^ inv_reg;
    end else if (wr_out) begin
      so_reg <= wdata[tx_channel_pkg::OUT_DATA_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!unit_rst_n) begin
      cko_reg <= tx_channel_pkg::OUT_CLK_RESET;
    end else if (wr_out && !oper_reg) begin
      cko_reg <= wdata[tx_channel_pkg::OUT_CLK_BIT];
    end
  end

  // Frame sequencer
  always_ff @(posedge core_clk) begin
    if (!unit_rst_n) begin
      state_reg <= tx_channel_pkg::ST_IDLE;
      idx_reg <= 4'h0;
      stop_cnt_reg <= 1'b0;
      shift_reg <= '0;
    end else if (wr_stop) begin
      state_reg <= tx_channel_pkg::ST_IDLE;
    end else begin
      case (state_reg)
        tx_channel_pkg::ST_IDLE: begin
          if (load) begin
            shift_reg <= buf_reg;
            state_reg <= tx_channel_pkg::ST_START;
          end
        end
        tx_channel_pkg::ST_START: begin
          if (bit_done) begin
            idx_reg <= 4'h0;
            state_reg <= tx_channel_pkg::ST_DATA;
          end
        end
        tx_channel_pkg::ST_DATA: begin
          if (bit_done) begin
            if (idx_reg == 4'(nbits - 4'h1)) begin
              stop_cnt_reg <= 1'b0;
              state_reg <= (par_reg == tx_channel_pkg::PAR_NONE) ?
                tx_channel_pkg::ST_STOP : tx_channel_pkg::ST_PARITY;
            end else begin
              idx_reg <= idx_reg + 4'h1;
            end
          end
        end
        tx_channel_pkg::ST_PARITY: begin
          if (bit_done) begin
            stop_cnt_reg <= 1'b0;
            state_reg <= tx_channel_pkg::ST_STOP;
          end
        end
        tx_channel_pkg::ST_STOP: begin
          if (bit_done) begin
            if (final_stop) begin
              state_reg <= tx_channel_pkg::ST_IDLE;
            end else begin
              stop_cnt_reg <= 1'b1;
            end
          end
        end
        default: state_reg <= tx_channel_pkg::ST_IDLE;
      endcase
    end
  end

  // Bit timer: a bit lasts twice the divider plus two channel clocks
  always_ff @(posedge core_clk) begin
    if (!unit_rst_n) begin
      tick_reg <= 8'h00;
    end else if (state_reg == tx_channel_pkg::ST_IDLE || bit_done || wr_stop) begin
      tick_reg <= 8'h00;
    end else if (ch_en) begin
      tick_reg <= tick_reg + 8'h01;
    end
  end

  // Select is frozen once the last bit of the frame has begun
  always_ff @(posedge core_clk) begin
    if (!unit_rst_n) begin
      iss_last_reg <= 1'b0;
    end else if (!final_stop) begin
      iss_last_reg <= iss_reg;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!unit_rst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= (frame_end && !iss_last_reg) || (load && iss_reg);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!unit_rst_n) begin
      rdata_reg <= 16'h0000;
    end else if (!rd_en) begin
      rdata_reg <= 16'h0000;
    end else begin
      case (addr)
        tx_channel_pkg::DATA_OFF: rdata_reg <= {div_reg, buf_reg};
        tx_channel_pkg::MODE_OFF: rdata_reg <= {4'h0, presc_reg, inv_reg, stop2_reg,
                                                len_reg, lsb_reg, par_reg, iss_reg};
        tx_channel_pkg::STATUS_OFF: rdata_reg <= {13'h0000, oper_reg,
                                                  state_reg != tx_channel_pkg::ST_IDLE,
                                                  bff_reg};
        tx_channel_pkg::OE_OFF: rdata_reg <= {15'h0000, oe_reg};
        tx_channel_pkg::OUT_OFF: rdata_reg <= {14'h0000, cko_reg, so_reg};
        tx_channel_pkg::PER_OFF: rdata_reg <= {15'h0000, per_reg};
        default: rdata_reg <= 16'h0000;
      endcase
    end
  end

  assign rdata = rdata_reg;
  assign transmit_line = so_reg;
  assign serial_clock_output = cko_reg;
  assign transmit_interrupt = irq_reg;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!unit_rst_n);

  sequence stop_req;
    wr_stop;
  endsequence

  sequence running_start;
    oper_reg && oe_reg && !wr_stop && state_reg == tx_channel_pkg::ST_START;
  endsequence

  stop_clears_flag_a: assert property (stop_req |=> !oper_reg && state_reg == tx_channel_pkg::ST_IDLE)
    else $error("stop write did not clear operating flag");
  start_bit_level_a: assert property (running_start ##1 running_start |-> transmit_line == inv_reg)
    else $error("start bit not at opposite of idle level");
  idle_line_level_a: assert property (oper_reg && oe_reg && !wr_stop && state_reg == tx_channel_pkg::ST_IDLE
      ##1 oper_reg && oe_reg |-> transmit_line == !inv_reg)
    else $error("idle line not at idle level");
  write_sets_full_a: assert property (wr_data |=> bff_reg && buf_reg == $past(wdata[8:0]))
    else $error("data write did not fill buffer");
  data_index_bound_a: assert property (state_reg == tx_channel_pkg::ST_DATA |-> idx_reg < nbits)
    else $error("data bit index beyond frame length");
  two_stop_bits_a: assert property (state_reg == tx_channel_pkg::ST_STOP && stop2_reg && !stop_cnt_reg
      && bit_done && !wr_stop |=> state_reg == tx_channel_pkg::ST_STOP && stop_cnt_reg)
    else $error("second stop bit skipped");
  parity_skip_a: assert property (state_reg == tx_channel_pkg::ST_DATA && bit_done && !wr_stop
      && idx_reg == 4'(nbits - 4'h1) && par_reg == tx_channel_pkg::PAR_NONE
      |=> state_reg == tx_channel_pkg::ST_STOP)
    else $error("parity bit sent when none selected");
  released_line_a: assert property (!oe_reg && !wr_out ##1 !oe_reg |-> $stable(transmit_line))
    else $error("line moved with output disabled");
  end_interrupt_a: assert property (frame_end && !iss_last_reg |=> transmit_interrupt)
    else $error("transfer end interrupt missing");
  min_divider_a: assert property (bit_done |-> tick_reg >= 8'h05)
    else $error("bit shorter than six channel clocks");
endmodule

/* tb/serial_rx_model.sv */
// Passive receiver model that captures the frames seen on the transmit line
`timescale 1ns/1ps
module serial_rx_model (
  input wire logic core_clk, // System clock
  input wire logic line, // Line under observation
  input wire logic armed, // Start detection allowed
  input wire logic inv, // Levels arrive inverted
  input wire logic [7:0] nbits, // Bits after the start bit, stops included
  input wire logic [7:0] bit_cycles, // Clock cycles per bit
  output logic [11:0] rx_bits, // Received bits, first one in bit 0
  output logic [7:0] frames // Frames received so far
);
  initial begin
    rx_bits = 12'h000;
    frames = 8'h00;
    forever begin
      @(posedge core_clk);
      // Start bit is the level opposite to idle
      if (armed === 1'b1 && line === inv) begin
        repeat (bit_cycles / 2) @(posedge core_clk);
        for (int i = 0; i < nbits; i++) begin
          repeat (bit_cycles) @(posedge core_clk);
          rx_bits[i] = line ^ inv;
        end
        frames = frames + 8'h01;
      end
    end
  end
endmodule

/* tb/test_async_serial_transmit_channel.sv */
// Register-level test of the transmit channel against a receiver model
`timescale 1ns/1ps
module test_async_serial_transmit_channel;
  logic core_clk;
  logic nrst;
  logic [7:0] addr;
  logic [15:0] wdata;
  logic wr_en;
  logic rd_en;
  logic [15:0] rdata;
  logic transmit_line;
  logic serial_clock_output;
  logic transmit_interrupt;
  logic armed;
  logic inv;
  logic [7:0] nbits;
  logic [7:0] bit_cycles;
  logic [11:0] rx_bits;
  logic [7:0] frames;
  logic [11:0] mask;
  logic [11:0] exp_a;
  logic [7:0] nf;
  int error_cnt;
  int num_checks;
  int n;
  logic [15:0] mode_tab [5] = '{16'h0028, 16'h0144, 16'h00be, 16'h00e2, 16'h001c};
  logic [6:0] div_tab [5] = '{7'h02, 7'h03, 7'h02, 7'h02, 7'h02};
  logic [8:0] word_tab [5] = '{9'h0a5, 9'h06b, 9'h1c3, 9'h0ff, 9'h17f};

  async_serial_transmit_channel dut (.core_clk(core_clk), .nrst(nrst), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .transmit_line(transmit_line), .serial_clock_output(serial_clock_output),
    .transmit_interrupt(transmit_interrupt));

  serial_rx_model partner (.core_clk(core_clk), .line(transmit_line), .armed(armed),
    .inv(inv), .nbits(nbits), .bit_cycles(bit_cycles), .rx_bits(rx_bits), .frames(frames));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    @(negedge core_clk);
    chk(rdata, exp);
  endtask

  // Pin levels once a register write has settled
  task automatic pins_chk(input logic [15:0] exp);
    repeat (2) @(negedge core_clk);
    chk({14'h0000, serial_clock_output, transmit_line}, exp);
  endtask

  // Waits for a frame count or for an interrupt pulse, bounded
  task automatic wait_ev(input logic by_frame, input logic [7:0] target);
    int t;
    t = 0;
    do begin
      @(negedge core_clk);
      t++;
    end while ((by_frame ? frames !== target : transmit_interrupt !== 1'b1) && t < 2000);
    if (t >= 2000) begin
      chk(16'h0000, 16'h0001);
      stop_test();
    end
  endtask

  function automatic logic [11:0] frame_bits(input logic [15:0] m, input logic [8:0] w,
                                            output int cnt);
    logic [11:0] v;
    logic p;
    int nb;
    v = 12'h000;
    p = 1'b0;
    nb = (m[5:4] == 2'h3) ? 9 : ((m[5:4] == 2'h2) ? 8 : 7);
    for (int i = 0; i < nb; i++) begin
      v[i] = m[3] ? w[i] : w[nb - 1 - i];
      p = p ^ w[i];
    end
    cnt = nb;
    if (m[2:1] != 2'h0) begin
      v[cnt] = (m[2:1] == 2'h1) ? 1'b0 : ((m[2:1] == 2'h2) ? p : ~p);
      cnt++;
    end
    v[cnt] = 1'b1;
    cnt++;
    if (m[6]) begin
      v[cnt] = 1'b1;
      cnt++;
    end
    return v;
  endfunction

  // Configures the channel and the model, presets the line and starts
  task automatic cfg(input logic [15:0] m, input logic [6:0] div);
    armed <= 1'b0;
    wr(tx_channel_pkg::MODE_OFF, m);
    inv <= m[7];
    nbits <= 8'(n);
    mask <= 12'((13'h0001 << n) - 13'h0001);
    bit_cycles <= 8'(({1'b0, div} + 8'h01) << (m[11:8] + 4'h1));
    wr(tx_channel_pkg::OUT_OFF, {14'h0000, 1'b1, ~m[7]});
    wr(tx_channel_pkg::OE_OFF, 16'h0001);
    wr(tx_channel_pkg::START_OFF, 16'h0001);
    armed <= 1'b1;
  endtask

  task automatic stop_chan(input logic iv);
    // Disarm first so later software line levels are not taken as frames
    armed <= 1'b0;
    wr(tx_channel_pkg::STOP_OFF, 16'h0001);
    rd(tx_channel_pkg::STATUS_OFF, 16'h0000);
    wr(tx_channel_pkg::OE_OFF, 16'h0000);
    pins_chk({14'h0000, 1'b1, ~iv});
  endtask

  initial begin
    nrst = 1'b0;
    addr = 8'h00;
    wdata = 16'h0000;
    wr_en = 1'b0;
    rd_en = 1'b0;
    armed = 1'b0;
    inv = 1'b0;
    nbits = 8'h0a;
    bit_cycles = 8'h06;
    mask = 12'h000;
    nf = 8'h00;
    error_cnt = 0;
    num_checks = 0;
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    @(negedge core_clk);
    chk({13'h0000, transmit_interrupt, serial_clock_output, transmit_line}, 16'h0003);
    rd(tx_channel_pkg::MODE_OFF, 16'h0020);
    rd(tx_channel_pkg::STATUS_OFF, 16'h0000);
    rd(tx_channel_pkg::START_OFF, 16'h0000);
    rd(8'h20, 16'h0000);
    $display("test reset done");
    for (int k = 0; k < 5; k++) begin
      exp_a = frame_bits(mode_tab[k], word_tab[k], n);
      cfg(mode_tab[k], div_tab[k]);
      wr(tx_channel_pkg::DATA_OFF, {div_tab[k], word_tab[k]});
      nf = nf + 8'h01;
      wait_ev(1'b0, 8'h00);
      chk({8'h00, frames}, {8'h00, nf});
      chk({4'h0, rx_bits & mask}, {4'h0, exp_a});
      stop_chan(mode_tab[k][7]);
      $display("test frame %0d done", k);
    end
    wr(tx_channel_pkg::OUT_OFF, 16'h0000);
    pins_chk(16'h0000);
    wr(tx_channel_pkg::OUT_OFF, 16'h0003);
    pins_chk(16'h0003);
    $display("test stopped levels done");
    exp_a = frame_bits(16'h0029, 9'h03c, n);
    cfg(16'h0029, 7'h02);
    wr(tx_channel_pkg::DATA_OFF, {7'h02, 9'h03c});
    wait_ev(1'b0, 8'h00);
    wr(tx_channel_pkg::DATA_OFF, {7'h02, 9'h111});
    rd(tx_channel_pkg::STATUS_OFF, 16'h0007);
    wr(tx_channel_pkg::DATA_OFF, {7'h02, 9'h0c3});
    nf = nf + 8'h01;
    wait_ev(1'b1, nf);
    chk({4'h0, rx_bits & mask}, {4'h0, exp_a});
    nf = nf + 8'h01;
    wait_ev(1'b1, nf);
    chk({4'h0, rx_bits & mask}, {4'h0, frame_bits(16'h0029, 9'h0c3, n)});
    repeat (200) @(negedge core_clk);
    chk({8'h00, frames}, {8'h00, nf});
    stop_chan(1'b0);
    $display("test continuous done");
    cfg(16'h0028, 7'h02);
    wr(tx_channel_pkg::DATA_OFF, {7'h02, 9'h055});
    repeat (20) @(posedge core_clk);
    wr(tx_channel_pkg::PER_OFF, 16'h0000);
    wr(tx_channel_pkg::PER_OFF, 16'h0001);
    rd(tx_channel_pkg::STATUS_OFF, 16'h0000);
    rd(tx_channel_pkg::MODE_OFF, 16'h0020);
    pins_chk(16'h0003);
    $display("test unit reset done");
    stop_test();
  end
endmodule
